// File: rtl/csl_pkg.sv
// package: constants, register map and state types for clock/power control
package csl_pkg;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int WDT_CLK_HZ = 32768;
  // clock-stable wait after wake, in ns
  localparam int WAKE_SETTLE_NS = 2000;
  localparam int WAKE_SETTLE_CYC =
    (WAKE_SETTLE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int WDT_W = 16;

  // strap codes
  localparam logic [2:0] STRAP_XTAL_19M2 = 3'h0;
  localparam logic [2:0] STRAP_CLK_19M2  = 3'h4;
  localparam logic [2:0] STRAP_CLK_26M   = 3'h5;
  localparam logic [2:0] STRAP_CLK_38M4  = 3'h6;
  localparam logic [2:0] STRAP_CLK_52M   = 3'h7;

  // pll multiply codes (fixed core rate whatever the reference)
  localparam logic [2:0] PLL_MUL_19M2 = 3'h0;
  localparam logic [2:0] PLL_MUL_26M  = 3'h1;
  localparam logic [2:0] PLL_MUL_38M4 = 3'h2;
  localparam logic [2:0] PLL_MUL_52M  = 3'h3;
  localparam logic [2:0] PLL_MUL_BAD  = 3'h7;

  // register offsets
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_WDT_LOAD = 4'h1;
  localparam logic [3:0] REG_STATUS   = 4'h2;
  localparam logic [3:0] REG_INT_STAT = 4'h3;
  localparam logic [3:0] REG_INT_MASK = 4'h4;
  localparam logic [3:0] REG_WAKE_EN  = 4'h5;

  // ctrl fields
  localparam int CTRL_WDT_EN     = 0;
  localparam int CTRL_WDT_IRQ    = 1;
  localparam int CTRL_WDT_WAKE   = 2;
  localparam int CTRL_WDT_RST    = 3;
  localparam int CTRL_CTS_POL    = 4;
  localparam int CTRL_REQ_LSB    = 8;
  localparam int CTRL_REQ_W      = 3;
  localparam int CTRL_WDT_KICK   = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // low-power request codes
  localparam logic [2:0] REQ_NONE     = 3'h0;
  localparam logic [2:0] REQ_SUSP_ON  = 3'h1;
  localparam logic [2:0] REQ_SUSP_OFF = 3'h2;
  localparam logic [2:0] REQ_STANDBY  = 3'h3;
  localparam logic [2:0] REQ_PWR_DOWN = 3'h4;

  // interrupt bits
  localparam int IRQ_WDT   = 0;
  localparam int IRQ_WAKE  = 1;
  localparam int IRQ_BADST = 2;
  localparam int IRQ_W     = 3;

  localparam int NUM_WAKE = 7;

  typedef enum logic [2:0] {
    PS_NORMAL   = 3'b000,
    PS_SUSP_ON  = 3'b001,
    PS_SUSP_OFF = 3'b010,
    PS_STANDBY  = 3'b011,
    PS_PWR_DOWN = 3'b100,
    PS_SETTLE   = 3'b101
  } csl_state_t;
endpackage

// File: rtl/csl_sync.sv
// module: three-stage input synchroniser with agree filter
`timescale 1ns/10ps
module csl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  // stage one feeds stage two only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dout <= RESET_VAL;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule

// File: rtl/csl_top.sv
// module: clock select, watchdog and low-power sequencer
`timescale 1ns/10ps
module csl_top
  import csl_pkg::*;
#(
  parameter int SETTLE_CYC = WAKE_SETTLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  ref_freq_select_strap,
  input  wire logic        slow_watchdog_clock_pin,
  input  wire logic        ext_suspend_req,
  input  wire logic [2:0]  ext_suspend_mode,
  input  wire logic        hard_reset_pin_n,
  input  wire logic        dp_line,
  input  wire logic        dm_line,
  input  wire logic        id_sense_pin,
  input  wire logic        high_rate_rx_pair_resume,
  input  wire logic        vbus_detect,
  input  wire logic        uart_cts,
  input  wire logic        control_input_zero,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  output logic             use_crystal,
  output logic [2:0]       pll_mult,
  output logic             pll_enable,
  output logic             cpu_clk_enable,
  output logic             periph_clk_enable,
  output logic             phy_enable,
  output logic             phy_u3,
  output logic             io_hold,
  output logic             core_power_off,
  output logic             cpu_halt,
  output logic             cpu_pc_reset
);
  logic [31:0]         ctrl;
  logic [WDT_W-1:0]    wdt_load;
  logic [IRQ_W-1:0]    int_stat;
  logic [IRQ_W-1:0]    int_mask;
  logic [NUM_WAKE-1:0] wake_en;
  logic [NUM_WAKE-1:0] wake_raw;
  logic [NUM_WAKE-1:0] wake_prev;
  logic [NUM_WAKE-1:0] wake_hit;
  logic [NUM_WAKE-1:0] wake_sync;
  logic                slow_sync;
  logic                slow_prev;
  logic                wdt_tick;
  logic                wdt_expire;
  logic [WDT_W-1:0]    wdt_count;
  logic                strap_done;
  logic [2:0]          strap;
  csl_state_t          state;
  csl_state_t          next_state;
  logic [15:0]         settle_cnt;
  logic                wake_pc_reset;
  logic                wake_any;
  logic                fw_req;
  logic [2:0]          req_mode;
  logic                bad_req;
  logic                wdt_fire;

  localparam int W_DP   = 0;
  localparam int W_DM   = 1;
  localparam int W_ID   = 2;
  localparam int W_RX   = 3;
  localparam int W_VBUS = 4;
  localparam int W_CTS  = 5;
  localparam int W_CIN0 = 6;

  // dp, dm and id wake on either edge, rx on a rising edge, vbus and cin0 on high level, cts is a polarity level
  assign wake_raw = {control_input_zero, uart_cts, vbus_detect,
                     high_rate_rx_pair_resume, id_sense_pin,
                     dm_line, dp_line};

  csl_sync #(.RESET_VAL(1'b0)) u_slow_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     (slow_watchdog_clock_pin),
    .dout    (slow_sync)
  );

  for (genvar i = 0; i < NUM_WAKE; i++) begin : g_wake
    csl_sync #(.RESET_VAL(1'b0)) u_wsync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     (wake_raw[i]),
      .dout    (wake_sync[i])
    );
  end

  // hard reset pin stays async to this clock too
  logic hrst_sync_n;
  csl_sync #(.RESET_VAL(1'b1)) u_hrst_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     (hard_reset_pin_n),
    .dout    (hrst_sync_n)
  );

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      slow_prev <= 1'b0;
      wake_prev <= '0;
    end else begin
      slow_prev <= slow_sync;
      wake_prev <= wake_sync;
    end
  end

  assign wdt_tick = slow_sync && !slow_prev;

  always_comb begin
    wake_hit = wake_sync ^ wake_prev;
    wake_hit[W_RX] = wake_sync[W_RX] && !wake_prev[W_RX];
    wake_hit[W_VBUS] = wake_sync[W_VBUS];
    wake_hit[W_CTS] = wake_sync[W_CTS] == ctrl[CTRL_CTS_POL];
    wake_hit[W_CIN0] = wake_sync[W_CIN0];
  end

  assign wake_any = |(wake_hit & wake_en);

  csl_wdt #(.W(WDT_W)) u_wdt (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .enable  (ctrl[CTRL_WDT_EN]),
    .tick    (wdt_tick),
    .kick    (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_WDT_KICK]),
    .load    (wdt_load),
    .expire  (wdt_expire),
    .count   (wdt_count)
  );

  assign wdt_fire = wdt_expire && ctrl[CTRL_WDT_EN];

  // strap caught once after reset release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      strap      <= STRAP_XTAL_19M2;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap      <= ref_freq_select_strap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      use_crystal <= 1'b1;
      pll_mult    <= PLL_MUL_19M2;
    end else begin
      use_crystal <= strap == STRAP_XTAL_19M2;
      unique case (strap)
        STRAP_XTAL_19M2: pll_mult <= PLL_MUL_19M2;
        STRAP_CLK_19M2:  pll_mult <= PLL_MUL_19M2;
        STRAP_CLK_26M:   pll_mult <= PLL_MUL_26M;
        STRAP_CLK_38M4:  pll_mult <= PLL_MUL_38M4;
        STRAP_CLK_52M:   pll_mult <= PLL_MUL_52M;
        default:         pll_mult <= PLL_MUL_BAD;
      endcase
    end
  end

  // either requester may ask; firmware by register write
  assign fw_req = reg_wr && reg_addr == REG_CTRL &&
                  reg_wdata[CTRL_REQ_LSB +: CTRL_REQ_W] != REQ_NONE;
  assign req_mode = fw_req ? reg_wdata[CTRL_REQ_LSB +: CTRL_REQ_W]
                           : ext_suspend_mode;
  assign bad_req = (fw_req || ext_suspend_req) && req_mode > REQ_PWR_DOWN;

  always_comb begin
    next_state = state;
    unique case (state)
      PS_NORMAL: begin
        if (fw_req || ext_suspend_req) begin
          unique case (req_mode)
            REQ_SUSP_ON:  next_state = PS_SUSP_ON;
            REQ_SUSP_OFF: next_state = PS_SUSP_OFF;
            REQ_STANDBY:  next_state = PS_STANDBY;
            REQ_PWR_DOWN: next_state = PS_PWR_DOWN;
            default: next_state = PS_NORMAL;
          endcase
        end
      end
      PS_SUSP_ON, PS_SUSP_OFF: begin
        if (wake_any || !hrst_sync_n) next_state = PS_SETTLE;
      end
      PS_STANDBY: begin
        if (wake_any || !hrst_sync_n ||
            (wdt_fire && ctrl[CTRL_WDT_WAKE])) next_state = PS_SETTLE;
      end
      PS_PWR_DOWN: begin
        if (!hrst_sync_n) next_state = PS_SETTLE;
      end
      PS_SETTLE: begin
        if (settle_cnt == 16'(SETTLE_CYC - 1)) next_state = PS_NORMAL;
      end
      default: next_state = PS_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= PS_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || state != PS_SETTLE) begin
      settle_cnt <= '0;
    end else begin
      settle_cnt <= settle_cnt + 16'h1;
    end
  end

  // pc reset decided at the wake edge, applied when settling ends
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wake_pc_reset <= 1'b0;
    end else if (next_state == PS_SETTLE && state != PS_SETTLE) begin
      wake_pc_reset <= !hrst_sync_n || state == PS_STANDBY ||
                       state == PS_PWR_DOWN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pll_enable        <= 1'b1;
      cpu_clk_enable    <= 1'b1;
      periph_clk_enable <= 1'b1;
      phy_enable        <= 1'b1;
      phy_u3            <= 1'b0;
      io_hold           <= 1'b0;
      core_power_off    <= 1'b0;
      cpu_halt          <= 1'b0;
      cpu_pc_reset      <= 1'b0;
    end else begin
      // registers and ram are never cleared here; clocks gate, and core power drops in power-down
      pll_enable <= next_state == PS_NORMAL || next_state == PS_SETTLE;
      cpu_clk_enable <= next_state == PS_NORMAL;
      periph_clk_enable <= next_state == PS_NORMAL;
      phy_enable <= next_state == PS_NORMAL || next_state == PS_SUSP_ON ||
                    next_state == PS_SETTLE;
      phy_u3 <= next_state == PS_SUSP_ON;
      io_hold <= next_state == PS_SUSP_ON || next_state == PS_SUSP_OFF ||
                 next_state == PS_STANDBY;
      core_power_off <= next_state == PS_PWR_DOWN;
      cpu_halt <= next_state != PS_NORMAL;
      cpu_pc_reset <= (state == PS_SETTLE && next_state == PS_NORMAL &&
                       wake_pc_reset) ||
                      (wdt_fire && ctrl[CTRL_WDT_RST]);
    end
  end

  // register writes; ctrl request field is self-clearing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl     <= CTRL_RESET;
      wdt_load <= '1;
      int_mask <= '0;
      wake_en  <= '1;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          ctrl <= reg_wdata;
          ctrl[CTRL_REQ_LSB +: CTRL_REQ_W] <= REQ_NONE;
          ctrl[CTRL_WDT_KICK] <= 1'b0;
        end
        REG_WDT_LOAD: wdt_load <= reg_wdata[WDT_W-1:0];
        REG_INT_MASK: int_mask <= reg_wdata[IRQ_W-1:0];
        REG_WAKE_EN:  wake_en  <= reg_wdata[NUM_WAKE-1:0];
        default: ;
      endcase
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat &
                   ~((reg_wr && reg_addr == REG_INT_STAT) ?
                     reg_wdata[IRQ_W-1:0] : '0)) |
                  {bad_req,
                   state == PS_SETTLE && next_state == PS_NORMAL,
                   wdt_fire && ctrl[CTRL_WDT_IRQ]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:     reg_rdata <= ctrl;
        REG_WDT_LOAD: reg_rdata <= 32'(wdt_load);
        REG_STATUS:   reg_rdata <= {8'h0, 8'(wdt_count >> 8), 5'h0, strap,
                                    5'h0, state};
        REG_INT_STAT: reg_rdata <= 32'(int_stat);
        REG_INT_MASK: reg_rdata <= 32'(int_mask);
        REG_WAKE_EN:  reg_rdata <= 32'(wake_en);
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// File: rtl/csl_wdt.sv
// module: watchdog counter stepped by synchronised 32 khz ticks
`timescale 1ns/10ps
module csl_wdt
  import csl_pkg::*;
#(
  parameter int W = WDT_W
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         enable,
  input  wire logic         tick,
  input  wire logic         kick,
  input  wire logic [W-1:0] load,
  output logic              expire,
  output logic [W-1:0]      count
);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count  <= '1; // full count, no false expiry after reset
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!enable || kick) begin
        count <= load;
      end else if (tick) begin
        if (count == '0) begin
          expire <= 1'b1;
          count  <= load;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule

// File: tb/csl_host.sv
// partner: external processor side issuing low-power requests
`timescale 1ns/10ps
module csl_host (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [2:0] mode,
  output logic            ext_suspend_req,
  output logic [2:0]      ext_suspend_mode
);
  logic       req_q  = 1'b0;
  logic [2:0] mode_q = 3'h0;
  logic [2:0] drift  = 3'h0;
  // one-cycle request, issued the cycle after go with no idle check
  always @(posedge sys_clk) begin
    req_q  <= go;
    mode_q <= mode;
    drift  <= drift + 3'h1;
  end
  assign ext_suspend_req  = req_q;
  // code means nothing outside a request, so it wanders
  assign ext_suspend_mode = req_q ? mode_q : drift;
endmodule

// File: tb/csl_top_asserts.sv
// checker: port-level properties of the clock/power control block
`timescale 1ns/10ps
module csl_top_asserts
  import csl_pkg::*;
#(
  parameter int SETTLE_CYC = WAKE_SETTLE_CYC
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [2:0] ref_freq_select_strap,
  input wire logic       hard_reset_pin_n,
  input wire logic       use_crystal,
  input wire logic [2:0] pll_mult,
  input wire logic       pll_enable,
  input wire logic       cpu_clk_enable,
  input wire logic       periph_clk_enable,
  input wire logic       phy_enable,
  input wire logic       phy_u3,
  input wire logic       io_hold,
  input wire logic       cpu_pc_reset
);
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] age;
  logic [7:0] settle_cnt;
  logic [2:0] exp_mult;
  // strap only trusted once its sample edge has passed
  always_ff @(posedge sys_clk) begin
    if (!reset_n) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  // cycles with plls up but cpu still gated
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !pll_enable || cpu_clk_enable) settle_cnt <= 8'h0;
    else if (settle_cnt != 8'hff) settle_cnt <= settle_cnt + 8'h1;
  end
  always_comb begin
    case (ref_freq_select_strap)
      STRAP_XTAL_19M2, STRAP_CLK_19M2: exp_mult = PLL_MUL_19M2;
      STRAP_CLK_26M:  exp_mult = PLL_MUL_26M;
      STRAP_CLK_38M4: exp_mult = PLL_MUL_38M4;
      STRAP_CLK_52M:  exp_mult = PLL_MUL_52M;
      default:        exp_mult = PLL_MUL_BAD;
    endcase
  end
  sequence s_pin_wake;
    io_hold && $fell(hard_reset_pin_n);
  endsequence
  sequence s_released;
    ##[1:8] !io_hold;
  endsequence
  property p_crystal;
    age == 2'h3 |-> use_crystal == (ref_freq_select_strap == STRAP_XTAL_19M2);
  endproperty
  property p_mult;
    age == 2'h3 |-> pll_mult == exp_mult;
  endproperty
  property p_normal_clks;
    cpu_clk_enable |-> pll_enable && periph_clk_enable;
  endproperty
  property p_u3_gating;
    phy_u3 |-> phy_enable && !pll_enable && !cpu_clk_enable
      && !periph_clk_enable;
  endproperty
  property p_u3_hold;
    phy_u3 |-> io_hold;
  endproperty
  property p_phy_off;
    !phy_enable |-> !pll_enable && !cpu_clk_enable;
  endproperty
  property p_settle;
    $rose(cpu_clk_enable) |-> int'(settle_cnt) >= SETTLE_CYC - 1;
  endproperty
  property p_pc_pulse;
    cpu_pc_reset |=> !cpu_pc_reset;
  endproperty
  property p_hard_wake;
    s_pin_wake |-> s_released;
  endproperty
  a_crystal: assert property (p_crystal)
    else $error("crystal select does not follow strap");
  a_mult: assert property (p_mult)
    else $error("pll multiply does not follow strap");
  a_normal_clks: assert property (p_normal_clks)
    else $error("cpu clock on without plls");
  a_u3_gating: assert property (p_u3_gating)
    else $error("clock running while phy in u3");
  a_u3_hold: assert property (p_u3_hold)
    else $error("pins not held in suspend");
  a_phy_off: assert property (p_phy_off)
    else $error("plls on with phy off");
  a_settle: assert property (p_settle)
    else $error("cpu clock back before settle time");
  a_pc_pulse: assert property (p_pc_pulse)
    else $error("pc reset longer than one cycle");
  a_hard_wake: assert property (p_hard_wake)
    else $error("hard reset pin did not end suspend");
endmodule
bind csl_top csl_top_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_csl_chk (
  .sys_clk               (sys_clk),
  .reset_n               (reset_n),
  .ref_freq_select_strap (ref_freq_select_strap),
  .hard_reset_pin_n      (hard_reset_pin_n),
  .use_crystal           (use_crystal),
  .pll_mult              (pll_mult),
  .pll_enable            (pll_enable),
  .cpu_clk_enable        (cpu_clk_enable),
  .periph_clk_enable     (periph_clk_enable),
  .phy_enable            (phy_enable),
  .phy_u3                (phy_u3),
  .io_hold               (io_hold),
  .cpu_pc_reset          (cpu_pc_reset)
);

// File: tb/test_csl_top.sv
// testbench: clock select, watchdog and low-power sequencer
`timescale 1ns/10ps
module test_csl_top;
  import csl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        slow    = 1'b0;
  logic        hrst_n  = 1'b1;
  logic        go      = 1'b0;
  logic        reg_wr  = 1'b0;
  logic        reg_rd  = 1'b0;
  logic        rd_seen = 1'b0;
  logic [2:0]  strap   = 3'h0;
  logic [2:0]  hmode   = 3'h1;
  logic [6:0]  wk      = 7'h20;
  logic [3:0]  addr    = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata, rv;
  logic [2:0]  rmode, mult;
  logic        req, irq, xtal, pll, cpu, per, phy, u3, hold, off, halt, pcr;
  logic [31:0] exp_q[$];
  logic [2:0]  sc[5] = '{STRAP_XTAL_19M2, STRAP_CLK_19M2, STRAP_CLK_26M,
                         STRAP_CLK_38M4, STRAP_CLK_52M};
  logic [2:0]  mc[5] = '{PLL_MUL_19M2, PLL_MUL_19M2, PLL_MUL_26M,
                         PLL_MUL_38M4, PLL_MUL_52M};
  // power outputs as {pll,cpu,per,phy,u3,hold,halt,off}, per state
  logic [7:0]  le[5] = '{8'hf0, 8'h1e, 8'h00, 8'h00, 8'h01};
  logic [7:0]  lm[5] = '{8'hff, 8'hff, 8'hf8, 8'hf8, 8'hc1};
  int          err_total = 0;
  int          checks    = 0;
  int          pc_cnt    = 0;
  int          seed      = 59;

  csl_top #(.SETTLE_CYC(4)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ref_freq_select_strap(strap),
    .slow_watchdog_clock_pin(slow), .ext_suspend_req(req),
    .ext_suspend_mode(rmode), .hard_reset_pin_n(hrst_n),
    .dp_line(wk[0]), .dm_line(wk[1]), .id_sense_pin(wk[2]),
    .high_rate_rx_pair_resume(wk[3]), .vbus_detect(wk[4]),
    .uart_cts(wk[5]), .control_input_zero(wk[6]), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .irq(irq), .use_crystal(xtal), .pll_mult(mult), .pll_enable(pll),
    .cpu_clk_enable(cpu), .periph_clk_enable(per), .phy_enable(phy),
    .phy_u3(u3), .io_hold(hold), .core_power_off(off), .cpu_halt(halt),
    .cpu_pc_reset(pcr)
  );
  csl_host host (
    .sys_clk(sys_clk), .go(go), .mode(hmode),
    .ext_suspend_req(req), .ext_suspend_mode(rmode)
  );

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // trailing idle cycle keeps strobes from being re-driven in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
  endtask
  task automatic host_req(input logic [2:0] m);
    hmode <= m;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(2);
  endtask
  task automatic lvl(input logic [7:0] e, input logic [7:0] m);
    @(negedge sys_clk);
    chk("power_outputs", {24'h0, {pll, cpu, per, phy, u3, hold, halt, off}
        & m}, {24'h0, e & m});
    @(posedge sys_clk);
  endtask
  task automatic irq_is(input logic e);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic wait_wake(input int pcs);
    int n;
    int p0;
    n = 0;
    p0 = pc_cnt;
    @(negedge sys_clk);
    while (cpu !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (4) @(negedge sys_clk);
    chk("woken", {31'h0, cpu}, 32'h1);
    chk("pc_resets", pc_cnt - p0, pcs);
    @(posedge sys_clk);
  endtask

  initial forever #12.5 sys_clk = ~sys_clk;
  // slow tick far faster than 32 khz to keep the run short
  always begin
    cyc(8);
    slow <= ~slow;
  end
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) chk("reg_rdata", rdata, exp_q.pop_front());
    if (pcr === 1'b1) pc_cnt++;
  end
  initial begin
    #(25 * 20000);
    err_total++;
    complete_run;
  end

  initial begin
    int k;
    for (k = 0; k < 5; k++) begin
      reset_n <= 1'b0;
      strap <= sc[k];
      cyc(3);
      reset_n <= 1'b1;
      cyc(3);
      @(negedge sys_clk);
      chk("use_crystal", {31'h0, xtal}, {31'h0, k == 0});
      chk("pll_mult", {29'h0, mult}, {29'h0, mc[k]});
      @(posedge sys_clk);
      lvl(le[0], lm[0]);
    end
    $display("test strap done");
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_WDT_LOAD, 32'hffff);
    rd(REG_INT_MASK, 32'h0);
    rd(REG_WAKE_EN, 32'h7f);
    rd(4'hf, 32'h0);
    rv = $random(seed);
    // load kept large so the watchdog stays quiet in the wake tests
    wr(REG_WDT_LOAD, {16'h0, 1'b1, rv[14:0]});
    rd(REG_WDT_LOAD, {16'h0, 1'b1, rv[14:0]});
    $display("test registers done");
    for (k = 0; k < 7; k++) begin
      if (k[0]) host_req(REQ_SUSP_ON);
      else wr(REG_CTRL, 32'h101);
      lvl(le[1], lm[1]);
      wk[k] <= ~wk[k];
      wait_wake(0);
      wk[k] <= ~wk[k];
      cyc(8);
    end
    // cts polarity flipped to the idle level wakes at once
    wr(REG_CTRL, 32'h111);
    wait_wake(0);
    wr(REG_CTRL, 32'h1);
    rd(REG_WDT_LOAD, {16'h0, 1'b1, rv[14:0]});
    rd(REG_INT_STAT, 32'h2);
    irq_is(1'b0);
    wr(REG_INT_MASK, 32'h2);
    irq_is(1'b1);
    wr(REG_INT_STAT, 32'h2);
    irq_is(1'b0);
    rd(REG_INT_STAT, 32'h0);
    $display("test wake sources done");
    for (k = 1; k < 5; k++) begin
      host_req(k[2:0]);
      lvl(le[k], lm[k]);
      hrst_n <= 1'b0;
      cyc(6);
      hrst_n <= 1'b1;
      wait_wake(1);
    end
    wr(REG_INT_STAT, 32'h7);
    host_req(3'h5);
    lvl(le[0], lm[0]);
    rd(REG_INT_STAT, 32'h4);
    $display("test low-power states done");
    wr(REG_INT_STAT, 32'h7);
    wr(REG_WDT_LOAD, 32'h2);
    // kick so the short reload takes effect at once
    wr(REG_CTRL, 32'h1005);
    host_req(REQ_STANDBY);
    wait_wake(1);
    k = pc_cnt;
    wr(REG_CTRL, 32'hb);
    cyc(150);
    chk("wdt_core_reset", {31'h0, pc_cnt > k}, 32'h1);
    rd(REG_INT_STAT, 32'h3);
    wr(REG_CTRL, 32'ha);
    wr(REG_INT_STAT, 32'h7);
    k = pc_cnt;
    cyc(150);
    chk("wdt_quiet", pc_cnt - k, 32'h0);
    rd(REG_INT_STAT, 32'h0);
    $display("test watchdog done");
    complete_run;
  end
endmodule
